// File: inc/cocr_defines.vh
// Purpose: constants for the calibration offset and clock register slice
// Assumes: 8-bit register index, 16-bit register data
// Notes: definitions only
`ifndef COCR_DEFINES_VH
`define COCR_DEFINES_VH
`define COCR_ADDR_BLUE 8'h62
`define COCR_ADDR_RED 8'h63
`define COCR_ADDR_GREEN_TWO 8'h64
`define COCR_ADDR_CLOCK 8'h65
`define COCR_OFS_MSB 8
`define COCR_OFS_SIGN 8
`define COCR_CLK_BYPASS 15
`define COCR_CLK_PLL_PD 14
`define COCR_CLK_STBY_PD 13
`define COCR_CLK_NEWROW 2
`define COCR_CLK_NEWFRAME 1
`define COCR_CLK_SHIP 0
`define COCR_OFS_RESET 9'h000
`define COCR_CLK_RESET 16'hE000
`define COCR_CLK_MASK 16'hE007
`endif

// File: rtl/cocr_offset_chan.v
// Purpose: one colour channel calibration offset holder
// Assumes: inputs synchronous to mclk
// Notes: manual value only stored while override set
`timescale 1ns/100ps
`include "cocr_defines.vh"
module cocr_offset_chan #(
  parameter WIDTH = 9
) (
  input wire mclk,
  input wire resetn,
  input wire manual_override,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  input wire [WIDTH-1:0] auto_value,
  output reg [WIDTH-1:0] offset
);
  reg [WIDTH-1:0] manual_value;
  // ------------------------------------------------------------
  // manual value store
  // ------------------------------------------------------------
  // writes dropped in auto
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      manual_value <= `COCR_OFS_RESET;
    end else if (wr_en && manual_override) begin
      manual_value <= wr_data;
    end
  end
  // effective value, registered so readback and output agree
  // auto value shown
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      offset <= `COCR_OFS_RESET;
    end else if (manual_override) begin
      offset <= (wr_en) ? wr_data : manual_value;
    end else begin
      offset <= auto_value;
    end
  end
endmodule // cocr_offset_chan

// File: rtl/cocr_offset_apply.v
// Purpose: convert a 9-bit two's complement offset to signed 10 bit
// Assumes: bit 8 is sign, bits 7:0 hold the two's complement low byte
// Notes: purely combinational
`timescale 1ns/100ps
`include "cocr_defines.vh"
module cocr_offset_apply (
  input wire [8:0] offset,
  output wire [9:0] signed_offset,
  output wire [7:0] magnitude,
  output wire negative
);
  // negative magnitude is inverse plus one
  assign negative = offset[`COCR_OFS_SIGN];
  assign magnitude = negative ? (~offset[7:0] + 8'h01) : offset[7:0];
  assign signed_offset = {offset[8], offset};
endmodule // cocr_offset_apply

// File: rtl/cocr_calib_clock_regs.v
// Purpose: calibration offsets for blue, red, second green and clock register
// Assumes: register access by index/data/strobe, synchronous to mclk
//   the override level comes from the black-level control slice
//   standby comes from the power controller, already synchronous
// Notes: outputs registered; read data valid one cycle after a read strobe
//   index 0x62 blue offset, 0x63 red offset, 0x64 second green offset
//   index 0x65 clock control; only bits 15, 14, 13, 2, 1 and 0 are kept
//   clock outputs follow a write two edges later
//   offset mirrors lag the algorithm inputs by two edges
//   a manual write is visible on readback one edge after it lands
//   unmapped reads return zero with the hit flag clear
//   the first green offset and the override bit live in neighbouring slices
//   no wait states: every request is taken on the edge that sees it
`timescale 1ns/100ps
`include "cocr_defines.vh"
module cocr_calib_clock_regs #(
  parameter OFS_WIDTH = 9
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg reg_hit,
  input wire manual_override,
  input wire standby,
  input wire pixel_is_blue_row,
  input wire pixel_is_green,
  input wire [OFS_WIDTH-1:0] auto_blue,
  input wire [OFS_WIDTH-1:0] auto_red,
  input wire [OFS_WIDTH-1:0] auto_green_two,
  output reg [OFS_WIDTH-1:0] blue_offset,
  output reg [OFS_WIDTH-1:0] red_offset,
  output reg [OFS_WIDTH-1:0] green_two_offset,
  output reg [OFS_WIDTH-1:0] pixel_offset,
  output reg [7:0] pixel_offset_magnitude,
  output reg pixel_offset_negative,
  output reg use_external_clock_input,
  output reg pll_power_down,
  output reg force_clk_newrow,
  output reg force_clk_newframe,
  output reg force_clk_ship
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  reg sel_blue;
  reg sel_red;
  reg sel_green_two;
  reg sel_clock;
  // one-hot selects; an index outside the slice leaves all clear
  // so writes there fall through and reads report no hit
  // if/else chain keeps the decode priority explicit
  always @* begin
    sel_blue = 1'b0;
    sel_red = 1'b0;
    sel_green_two = 1'b0;
    sel_clock = 1'b0;
    if (reg_addr == `COCR_ADDR_BLUE) begin
      sel_blue = 1'b1;
    end else if (reg_addr == `COCR_ADDR_RED) begin
      sel_red = 1'b1;
    end else if (reg_addr == `COCR_ADDR_GREEN_TWO) begin
      sel_green_two = 1'b1;
    end else if (reg_addr == `COCR_ADDR_CLOCK) begin
      sel_clock = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // offset channels
  // ------------------------------------------------------------
  // effective values; each lags its algorithm input by one edge
  // the write path bypasses the stored value for one edge so a
  // manual write and the effective output agree without a stall
  wire [OFS_WIDTH-1:0] ofs_blue;
  wire [OFS_WIDTH-1:0] ofs_red;
  wire [OFS_WIDTH-1:0] ofs_green_two;
  // blue pixels, index 0x62
  // separate channel fields
  cocr_offset_chan #(.WIDTH(OFS_WIDTH)) u_blue (
    .mclk(mclk),
    .resetn(resetn),
    .manual_override(manual_override),
    .wr_en(reg_wr & sel_blue),
    .wr_data(reg_wdata[OFS_WIDTH-1:0]),
    .auto_value(auto_blue),
    .offset(ofs_blue)
  );
  // red pixels, index 0x63
  cocr_offset_chan #(.WIDTH(OFS_WIDTH)) u_red (
    .mclk(mclk),
    .resetn(resetn),
    .manual_override(manual_override),
    .wr_en(reg_wr & sel_red),
    .wr_data(reg_wdata[OFS_WIDTH-1:0]),
    .auto_value(auto_red),
    .offset(ofs_red)
  );
  // second green pixels, on blue rows, index 0x64
  cocr_offset_chan #(.WIDTH(OFS_WIDTH)) u_green_two (
    .mclk(mclk),
    .resetn(resetn),
    .manual_override(manual_override),
    .wr_en(reg_wr & sel_green_two),
    .wr_data(reg_wdata[OFS_WIDTH-1:0]),
    .auto_value(auto_green_two),
    .offset(ofs_green_two)
  );

  // ------------------------------------------------------------
  // clock register
  // ------------------------------------------------------------
  reg [15:0] clock_ctrl;
  // unused bits are masked on write, so they always read zero
  // and no stray flop is kept for them
  // bypass resets to one
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clock_ctrl <= `COCR_CLK_RESET;
    end else if (reg_wr && sel_clock) begin
      clock_ctrl <= reg_wdata & `COCR_CLK_MASK;
    end
  end

  // ------------------------------------------------------------
  // pixel offset selection
  // ------------------------------------------------------------
  // the choice is combinational so a row or colour change reaches
  // the registered output on the very next edge
  reg [OFS_WIDTH-1:0] next_pixel_offset;
  // blue rows use blue and second green
  always @* begin
    if (pixel_is_blue_row) begin
      next_pixel_offset = pixel_is_green ? ofs_green_two : ofs_blue;
    end else begin
      // red rows: first green lives elsewhere, red handled here
      next_pixel_offset = ofs_red;
    end
  end
  // sign and size decode shared by all three channels
  wire [9:0] conv_signed;
  wire [7:0] conv_mag;
  wire conv_neg;
  cocr_offset_apply u_apply (
    .offset(next_pixel_offset),
    .signed_offset(conv_signed),
    .magnitude(conv_mag),
    .negative(conv_neg)
  );

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  // mirrors let the analog side see a steady value while reads happen
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blue_offset <= `COCR_OFS_RESET;
      red_offset <= `COCR_OFS_RESET;
      green_two_offset <= `COCR_OFS_RESET;
    end else begin
      blue_offset <= ofs_blue;
      red_offset <= ofs_red;
      green_two_offset <= ofs_green_two;
    end
  end

  // selected pixel offset with its sign and size, registered so
  // the pixel path downstream sees one clean edge
  // positive low byte
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pixel_offset <= `COCR_OFS_RESET;
      pixel_offset_magnitude <= 8'h00;
      pixel_offset_negative <= 1'b0;
    end else begin
      pixel_offset <= conv_signed[OFS_WIDTH-1:0];
      pixel_offset_magnitude <= conv_mag;
      pixel_offset_negative <= conv_neg;
    end
  end

  // ------------------------------------------------------------
  // clock control outputs
  // ------------------------------------------------------------
  // master clock source; resets to the external input so a part
  // whose PLL was never programmed still gets a clock
  // PLL clock when clear
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      use_external_clock_input <= 1'b1;
    end else begin
      use_external_clock_input <= clock_ctrl[`COCR_CLK_BYPASS];
    end
  end

  // PLL power: off if bit 14, else off in standby when bit 13 set;
  // standby is sampled every edge, so entry shows one cycle late
  // hard power-down
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pll_power_down <= 1'b1;
    end else begin
      pll_power_down <= clock_ctrl[`COCR_CLK_PLL_PD] |
        (clock_ctrl[`COCR_CLK_STBY_PD] & standby);
    end
  end

  // forced gates cost power; reset leaves all three gated
  // each is a plain copy of its control bit
  // new-row force
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      force_clk_newrow <= 1'b0;
    end else begin
      force_clk_newrow <= clock_ctrl[`COCR_CLK_NEWROW];
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      force_clk_newframe <= 1'b0;
    end else begin
      force_clk_newframe <= clock_ctrl[`COCR_CLK_NEWFRAME];
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      force_clk_ship <= 1'b0;
    end else begin
      force_clk_ship <= clock_ctrl[`COCR_CLK_SHIP];
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  reg [15:0] next_rdata;
  reg next_hit;
  // readback shows the effective value, so in auto mode the host
  // sees what the algorithm has settled on
  // upper bits zero
  always @* begin
    next_rdata = 16'h0000;
    next_hit = 1'b1;
    if (sel_blue) begin
      next_rdata[OFS_WIDTH-1:0] = ofs_blue;
    end else if (sel_red) begin
      next_rdata[OFS_WIDTH-1:0] = ofs_red;
    end else if (sel_green_two) begin
      next_rdata[OFS_WIDTH-1:0] = ofs_green_two;
    end else if (sel_clock) begin
      next_rdata = clock_ctrl;
    end else begin
      next_hit = 1'b0; // unmapped: zero, no hit
    end
  end

  // read capture; the data holds between reads so a slow host may
  // pick it up late without a second request
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end
endmodule // cocr_calib_clock_regs

// File: tb/cocr_calib_clock_regs_chk.sv
// Purpose: assertions on the register slice ports
// Assumes: single mclk domain, resetn async low
// Notes: bind at the foot
`timescale 1ns/100ps
module cocr_chk (
  input wire mclk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire reg_hit,
  input wire manual_override,
  input wire pixel_is_blue_row,
  input wire pixel_is_green,
  input wire [8:0] blue_offset,
  input wire [8:0] green_two_offset,
  input wire [8:0] pixel_offset,
  input wire [7:0] pixel_offset_magnitude,
  input wire pixel_offset_negative,
  input wire use_external_clock_input,
  input wire pll_power_down,
  input wire force_clk_newrow,
  input wire force_clk_ship
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // clock register write seen at the ports
  wire ck = reg_wr && reg_addr == 8'h65;
  sequence ofs_wr; manual_override && reg_wr && reg_addr == 8'h62; endsequence
  sequence quiet; manual_override && !reg_wr; endsequence
  chk_bypass_follows: assert property (ck |-> ##2 use_external_clock_input == $past(reg_wdata[15], 2))
    else $error("bypass mismatch");
  chk_force_gates: assert property (ck |-> ##2 {force_clk_newrow, force_clk_ship} ==
    {$past(reg_wdata[2], 2), $past(reg_wdata[0], 2)}) else $error("force mismatch");
  chk_pll_off: assert property (ck && reg_wdata[14] |-> ##2 pll_power_down)
    else $error("pll not down");
  chk_pll_on: assert property (ck && !reg_wdata[14] && !reg_wdata[13] |-> ##2 !pll_power_down)
    else $error("pll not up");
  chk_unmapped_rd: assert property (reg_rd && (reg_addr < 8'h62 || reg_addr > 8'h65) |=>
    !reg_hit && reg_rdata == 16'h0000) else $error("unmapped read");
  chk_ofs_upper: assert property (reg_rd && reg_addr >= 8'h62 && reg_addr <= 8'h64 |=>
    reg_hit && reg_rdata[15:9] == 7'h00) else $error("offset upper bits");
  chk_manual_wr: assert property (ofs_wr ##1 quiet [*2] |-> blue_offset == $past(reg_wdata[8:0], 2))
    else $error("manual write lost");
  chk_pixel_green: assert property (pixel_is_blue_row && pixel_is_green |=>
    pixel_offset == green_two_offset) else $error("pixel source");
  chk_pixel_sign: assert property (pixel_offset_negative == pixel_offset[8] && pixel_offset_magnitude ==
    (pixel_offset[8] ? ~pixel_offset[7:0] + 8'h01 : pixel_offset[7:0])) else $error("magnitude");
endmodule // cocr_chk
bind cocr_calib_clock_regs cocr_chk i_chk (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_hit, .manual_override, .pixel_is_blue_row, .pixel_is_green, .blue_offset,
  .green_two_offset, .pixel_offset, .pixel_offset_magnitude, .pixel_offset_negative,
  .use_external_clock_input, .pll_power_down, .force_clk_newrow, .force_clk_ship);

// File: tb/cocr_host.sv
// Purpose: host software model on the register side
// Assumes: design takes requests on rising mclk
// Notes: released lines show the inverse of the last value
`timescale 1ns/100ps
module cocr_host (
  input wire mclk,
  input wire [15:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  // read data stands from the edge after the request
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge mclk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask
endmodule // cocr_host

// File: tb/test_calib_offset_clock_regs.sv
// Purpose: self-checking bench for the register slice
// Assumes: 25 MHz mclk, inputs moved on falling edge
// Notes: random data from a fixed lfsr seed
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_calib_offset_clock_regs;
  logic mclk, resetn, manual_override, standby, pixel_is_blue_row, pixel_is_green;
  logic [8:0] auto_blue, auto_red, auto_green_two, e;
  logic [8:0] v [3];
  logic [7:0] a;
  logic [15:0] d, w;
  logic [31:0] seed = 32'h8E8C;
  int miscompares = 0, num_checks = 0, cycles = 0;
  wire [7:0] reg_addr, pixel_offset_magnitude;
  wire [15:0] reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_hit, pixel_offset_negative, use_external_clock_input, pll_power_down;
  wire force_clk_newrow, force_clk_newframe, force_clk_ship;
  wire [8:0] blue_offset, red_offset, green_two_offset, pixel_offset;
  cocr_calib_clock_regs i_dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_hit, .manual_override, .standby, .pixel_is_blue_row, .pixel_is_green, .auto_blue, .auto_red,
    .auto_green_two, .blue_offset, .red_offset, .green_two_offset, .pixel_offset, .pixel_offset_magnitude,
    .pixel_offset_negative, .use_external_clock_input, .pll_power_down, .force_clk_newrow,
    .force_clk_newframe, .force_clk_ship);
  cocr_host i_host (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // pll stays down when forced or when standby asks for it
  function automatic logic pd_exp(input logic [15:0] x, input logic sb);
    return x[14] | (x[13] & sb);
  endfunction
  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // hang guard, far above the two hundred or so cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {resetn, manual_override, standby, pixel_is_blue_row, pixel_is_green} = 5'h00;
    {auto_blue, auto_red, auto_green_two} = 27'h0;
    repeat (5) @(posedge mclk);
    @(negedge mclk) resetn = 1'b1;
    `CHK({use_external_clock_input, pll_power_down, force_clk_newrow, force_clk_ship}, 4'hC)
    i_host.rd(8'h65, d);
    `CHK(d, 16'hE000)
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (i == 2) ? 16'h2000 : seed[15:0];
      standby = seed[16];
      i_host.wr(8'h65, w);
      i_host.rd(8'h65, d);
      `CHK(d, w & 16'hE007)
      `CHK({use_external_clock_input, pll_power_down}, {w[15], pd_exp(w, standby)})
      `CHK({force_clk_newrow, force_clk_newframe, force_clk_ship}, w[2:0])
    end
    manual_override = 1'b1;
    for (int c = 0; c < 3; c++) begin
      seed = lfsr(seed);
      w = (c == 0) ? 16'hFF80 : (c == 2) ? 16'h007F : seed[15:0];
      a = 8'h62 + c[7:0];
      v[c] = w[8:0];
      i_host.wr(a, w);
      i_host.rd(a, d);
      `CHK({reg_hit, d}, {8'h80, w[8:0]})
    end
    for (int p = 0; p < 4; p++) begin
      {pixel_is_blue_row, pixel_is_green} = p[1:0];
      e = p[1] ? (p[0] ? v[2] : v[0]) : v[1];
      repeat (3) @(negedge mclk);
      `CHK(pixel_offset, e)
      `CHK({pixel_offset_negative, pixel_offset_magnitude}, {e[8], e[8] ? ~e[7:0] + 8'h01 : e[7:0]})
    end
    manual_override = 1'b0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      {auto_blue, auto_red, auto_green_two} = seed[26:0];
      for (int c = 0; c < 3; c++) begin
        a = 8'h62 + c[7:0];
        i_host.wr(a, ~seed[15:0]);
        i_host.rd(a, d);
        `CHK(d, {7'h00, seed[26 - 9 * c -: 9]})
      end
      `CHK({blue_offset, red_offset, green_two_offset}, seed[26:0])
    end
    // manual values survive the auto period
    manual_override = 1'b1;
    for (int c = 0; c < 3; c++) begin
      a = 8'h62 + c[7:0];
      i_host.rd(a, d);
      `CHK(d[8:0], v[c])
    end
    i_host.rd(8'h66, d);
    `CHK({reg_hit, d}, 17'h00000)
    end_sim();
  end
endmodule // test_calib_offset_clock_regs
